// >>> common/ctx_pkg.sv
// package for the tx cancel and rx store block: register map, fields, resets, states
// assumes an axi4-lite master and a simple protocol-engine and message-ram interface
// Overview of operation
// - auto retransmit runs when disable_auto_retransmit is 0; failed frame stays pending until the next start of frame
// - cancel request bit asks; success sets cancel finished and clears pending
// - cancel during retransmit id bits reports success only if frame really withdrawn
// - occurred bit set when buffer frame completes on bus, else stays zero
// - pending bit cleared tells software the buffer is free again
// - frame uses buffer data latched at start of frame; later writes ignored
// - rx handler reads filters from message ram, then writes accepted frames
// - rx data bytes cached and stored as 4-byte words r2..rn, n at most 17
// - word ri holds bytes 4*(i-2) upward, lowest byte in bits 7:0
// - r0 esi, xtd, rtr, id; r1 non_matching_accepted_flag, filter index, fdf, brs, dlc, timestamp
// - each stored data word holds its own bytes; never a copy of the previous
// - valid frame stored: put index updated or new data flag set; ram fail clear
// - filtering starts at element 0 and stops at the first match
package ctx_pkg;
  localparam int unsigned NBUF     = 4;
  localparam int unsigned NFILT    = 8;
  localparam int unsigned RAM_AW   = 8;
  localparam int unsigned MAX_WORD = 17;
  localparam int unsigned FIFO_LEN = 8;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_REQ    = 8'h04;
  localparam logic [7:0] OFS_CANCEL = 8'h08;
  localparam logic [7:0] OFS_PEND   = 8'h0c;
  localparam logic [7:0] OFS_CFIN   = 8'h10;
  localparam logic [7:0] OFS_OCC    = 8'h14;
  localparam logic [7:0] OFS_RXSTAT = 8'h18;
  localparam logic [7:0] OFS_NDAT   = 8'h1c;
  localparam logic [7:0] OFS_IRQST  = 8'h20;
  localparam logic [7:0] OFS_IRQCLR = 8'h24;
  localparam logic [7:0] OFS_IRQEN  = 8'h28;
  localparam logic [7:0] OFS_FCFG   = 8'h2c;
  // field positions
  localparam int unsigned CTRL_DAR   = 0;
  localparam int unsigned IRQ_TXDONE = 0;
  localparam int unsigned IRQ_CANCEL = 1;
  localparam int unsigned IRQ_RXNEW  = 2;
  localparam int unsigned IRQ_MRAF   = 3;
  localparam int unsigned NIRQ       = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // message ram layout: filters at 0, rx elements from RX_BASE
  localparam logic [7:0] RX_BASE    = 8'h20;
  localparam logic [7:0] ELEM_WORDS = 8'h12;
  localparam int unsigned ID_BITS   = 4;
  typedef enum logic [4:0] {
    CTX_IDLE  = 5'b00001,
    CTX_FILT  = 5'b00010,
    CTX_HDR   = 5'b00100,
    CTX_DATA  = 5'b01000,
    CTX_DONE  = 5'b10000
  } ctx_rx_e;
endpackage : ctx_pkg

// >>> rtl/ctx_ram.sv
// message ram model: one read/write port, registered read data
// assumes single-cycle access from one master at a time
`timescale 1ns/10ps
module ctx_ram (
  input  wire logic                         clk,
  input  wire logic                         we,
  input  wire logic [ctx_pkg::RAM_AW-1:0]   addr,
  input  wire logic [31:0]                  wdata,
  output logic      [31:0]                  rdata
);
  logic [31:0] mem [2**ctx_pkg::RAM_AW];
  // write and registered read
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule : ctx_ram

// >>> rtl/ctx_top.sv
// can controller slice: tx cancel handling and rx filter/store, axi4-lite registers
// assumes a protocol engine gives sof, id phase, done and rx word stream on clk
`timescale 1ns/10ps
module ctx_top (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [1:0]  tx_sel,
  input  wire logic        tx_sof,
  input  wire logic        tx_in_id,
  input  wire logic        tx_done_ok,
  input  wire logic        tx_done_err,
  output logic [31:0]      tx_frame_data,
  input  wire logic        rx_start,
  input  wire logic [28:0] rx_id,
  input  wire logic        rx_xtd,
  input  wire logic        rx_rtr,
  input  wire logic        rx_esi,
  input  wire logic        rx_fdf,
  input  wire logic        rx_brs,
  input  wire logic [3:0]  rx_dlc,
  input  wire logic [15:0] rx_timestamp,
  input  wire logic        rx_word_valid,
  input  wire logic [31:0] rx_word,
  input  wire logic        rx_end,
  input  wire logic        ram_host_we,
  input  wire logic [7:0]  ram_host_addr,
  input  wire logic [31:0] ram_host_wdata,
  output logic             irq
);
  localparam int unsigned NB = ctx_pkg::NBUF;
  typedef struct packed {
    logic                        awdone;
    logic                        wdone;
    logic [7:0]                  awaddr;
    logic [31:0]                 wdata;
    logic                        bvalid;
    logic                        rvalid;
    logic [31:0]                 rdata;
    logic [1:0]                  rresp;
    logic [31:0]                 ctrl;
    logic [31:0]                 fcfg;
    logic [ctx_pkg::NIRQ-1:0]    irq_st;
    logic [ctx_pkg::NIRQ-1:0]    irq_en;
    logic [NB-1:0]               occ_d;
    logic [NB-1:0]               cfin_d;
    ctx_pkg::ctx_rx_e            rx;
    logic [2:0]                  filter_index;
    logic                        hit;
    logic                        rd_wait;
    logic [28:0]                 id;
    logic [31:0]                 r0;
    logic [31:0]                 r1;
    logic [31:0]                 cache;
    logic                        cache_full;
    logic [4:0]                  widx;
    logic [2:0]                  put;
    logic [2:0]                  put_idx;
    logic [31:0]                 ndat;
  } ctx_s;
  ctx_s st, next_st;
  logic [NB-1:0]  pend, cfin, occ, act;
  logic [31:0]    fdat [NB];
  logic [NB-1:0]  req_set, cancel_set, wr_en, sof_v, ok_v, err_v;
  logic           ram_we;
  logic [7:0]     ram_addr;
  logic [31:0]    ram_wdata, ram_rdata;
  logic           wr_fire, rd_fire, busy_rx, rx_fifo_sel;
  logic [3:0]     rx_idx;
  ////////////////////////////////////////////////////////////////////
  // tx buffer slots
  genvar g;
  generate
    for (g = 0; g < NB; g++) begin : g_buf
      ctx_txbuf u_buf (
        .clk        (clk),
        .nrst       (nrst),
        .req_set    (req_set[g]),
        .cancel_set (cancel_set[g]),
        .dar        (st.ctrl[ctx_pkg::CTRL_DAR]),
        .sof        (sof_v[g]),
        .in_id      (tx_in_id && act[g]),
        .done_ok    (ok_v[g]),
        .done_err   (err_v[g]),
        .wr_data    (st.wdata),
        .wr_en      (wr_en[g]),
        .pending    (pend[g]),
        .cancel_fin (cfin[g]),
        .occurred   (occ[g]),
        .active     (act[g]),
        .frame_data (fdat[g])
      );
    end
  endgenerate
  assign tx_frame_data = fdat[tx_sel];
  ////////////////////////////////////////////////////////////////////
  // axi strobes
  assign wr_fire = st.awdone && st.wdone && !st.bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign s_axi_awready = !st.awdone && !st.bvalid;
  assign s_axi_wready  = !st.wdone && !st.bvalid;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = 2'h0;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;
  assign irq = |(st.irq_st & st.irq_en);
  // per-buffer decode; buffer data word at 0x40 + 4*n
  always_comb begin
    for (int i = 0; i < NB; i++) begin
      req_set[i]    = wr_fire && st.awaddr == ctx_pkg::OFS_REQ && st.wdata[i];
      cancel_set[i] = wr_fire && st.awaddr == ctx_pkg::OFS_CANCEL && st.wdata[i];
      wr_en[i]      = wr_fire && st.awaddr == (8'h40 + 8'(4*i));
      sof_v[i]      = tx_sof && tx_sel == 2'(i);
      ok_v[i]       = tx_done_ok && tx_sel == 2'(i);
      err_v[i]      = tx_done_err && tx_sel == 2'(i);
    end
  end
  ////////////////////////////////////////////////////////////////////
  // message ram; host writes filters when rx idle
  assign busy_rx     = st.rx != ctx_pkg::CTX_IDLE;
  assign rx_fifo_sel = st.fcfg[31];
  assign rx_idx      = rx_fifo_sel ? {1'b0, st.put} : st.fcfg[19:16];
  ctx_ram u_ram (
    .clk   (clk),
    .we    (ram_we),
    .addr  (ram_addr),
    .wdata (ram_wdata),
    .rdata (ram_rdata)
  );
  ////////////////////////////////////////////////////////////////////
  // next state: bus, irq, rx handler
  always_comb begin
    logic [7:0] base;
    base      = ctx_pkg::RX_BASE + 8'(rx_idx * ctx_pkg::ELEM_WORDS);
    next_st   = st;
    ram_we    = ram_host_we && !busy_rx;
    ram_addr  = ram_host_addr;
    ram_wdata = ram_host_wdata;
    if (s_axi_awvalid && s_axi_awready) begin
      next_st.awdone = 1'b1;
      next_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_st.wdone = 1'b1;
      next_st.wdata = s_axi_wdata;
    end
    if (wr_fire) begin
      next_st.awdone = 1'b0;
      next_st.wdone  = 1'b0;
      next_st.bvalid = 1'b1;
      if (st.awaddr == ctx_pkg::OFS_CTRL) next_st.ctrl = st.wdata;
      if (st.awaddr == ctx_pkg::OFS_FCFG) next_st.fcfg = st.wdata;
      if (st.awaddr == ctx_pkg::OFS_IRQEN) next_st.irq_en = st.wdata[ctx_pkg::NIRQ-1:0];
      if (st.awaddr == ctx_pkg::OFS_IRQCLR) next_st.irq_st = st.irq_st & ~st.wdata[ctx_pkg::NIRQ-1:0];
      if (st.awaddr == ctx_pkg::OFS_NDAT) next_st.ndat = st.ndat & ~st.wdata;
    end
    if (st.bvalid && s_axi_bready) next_st.bvalid = 1'b0;
    if (rd_fire) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = 2'h0;
      unique case (s_axi_araddr)
        ctx_pkg::OFS_CTRL:   next_st.rdata = st.ctrl;
        ctx_pkg::OFS_PEND:   next_st.rdata = 32'(pend);
        ctx_pkg::OFS_CFIN:   next_st.rdata = 32'(cfin);
        ctx_pkg::OFS_OCC:    next_st.rdata = 32'(occ);
        ctx_pkg::OFS_RXSTAT: next_st.rdata = 32'(st.put_idx);
        ctx_pkg::OFS_NDAT:   next_st.rdata = st.ndat;
        ctx_pkg::OFS_IRQST:  next_st.rdata = 32'(st.irq_st);
        ctx_pkg::OFS_IRQEN:  next_st.rdata = 32'(st.irq_en);
        ctx_pkg::OFS_FCFG:   next_st.rdata = st.fcfg;
        default: begin
          next_st.rdata = 32'h0;
          next_st.rresp = (s_axi_araddr < 8'h40) ? 2'h0 : 2'h2;
        end
      endcase
    end
    if (st.rvalid && s_axi_rready) next_st.rvalid = 1'b0;
    // sticky events; set wins over clear
    next_st.occ_d  = occ;
    next_st.cfin_d = cfin;
    if (|(occ & ~st.occ_d)) next_st.irq_st[ctx_pkg::IRQ_TXDONE] = 1'b1;
    if (|(cfin & ~st.cfin_d)) next_st.irq_st[ctx_pkg::IRQ_CANCEL] = 1'b1;
    // rx data words arrive into the cache
    if (rx_word_valid) begin
      next_st.cache      = rx_word;
      next_st.cache_full = 1'b1;
    end
    unique case (st.rx)
      ctx_pkg::CTX_IDLE: begin
        if (rx_start) begin
          next_st.rx      = ctx_pkg::CTX_FILT;
          next_st.filter_index    = 3'h0;
          next_st.rd_wait = 1'b1;
          next_st.id      = rx_id;
          next_st.r0      = {rx_esi, rx_xtd, rx_rtr, rx_id};
          next_st.r1      = {8'h00, 2'h0, rx_fdf, rx_brs, rx_dlc, rx_timestamp};
          next_st.hit     = 1'b0;
          next_st.widx    = 5'h2;
          next_st.cache_full = rx_word_valid;
        end
      end
      ctx_pkg::CTX_FILT: begin
        // read filters from element 0, stop at first match
        ram_addr = 8'(st.filter_index);
        ram_we   = 1'b0;
        if (st.rd_wait) begin
          next_st.rd_wait = 1'b0;
        end else if (ram_rdata[31] && ((ram_rdata[28:0] ^ st.id) & st.fcfg[28:0]) == 29'h0) begin
          next_st.hit = 1'b1;
          next_st.rx  = ctx_pkg::CTX_HDR;
        end else if (st.filter_index == 3'(ctx_pkg::NFILT - 1)) begin
          next_st.rx = st.fcfg[30] ? ctx_pkg::CTX_HDR : ctx_pkg::CTX_IDLE;
        end else begin
          next_st.filter_index    = st.filter_index + 3'h1;
          next_st.rd_wait = 1'b1;
        end
        // non-match flag and filter index into r1
        next_st.r1[31]    = !next_st.hit;
        next_st.r1[30:24] = 7'(st.filter_index);
      end
      ctx_pkg::CTX_HDR: begin
        ram_we    = 1'b1;
        ram_addr  = base + {3'h0, st.widx[4:0] == 5'h2 ? 5'h0 : 5'h1};
        ram_wdata = st.widx == 5'h2 ? st.r0 : st.r1;
        next_st.widx = st.widx == 5'h2 ? 5'h3 : 5'h2;
        if (st.widx != 5'h2) next_st.rx = ctx_pkg::CTX_DATA;
      end
      ctx_pkg::CTX_DATA: begin
        // store each cached word once, own bytes only
        if (st.cache_full) begin
          ram_we    = 1'b1;
          ram_addr  = base + 8'(st.widx);
          ram_wdata = st.cache;
          next_st.cache_full = rx_word_valid;
          next_st.widx = st.widx + 5'h1;
        end
        if (rx_end && !st.cache_full && !rx_word_valid) next_st.rx = ctx_pkg::CTX_DONE;
        if (st.widx == 5'(ctx_pkg::MAX_WORD + 1)) next_st.rx = ctx_pkg::CTX_DONE;
      end
      ctx_pkg::CTX_DONE: begin
        // report stored frame, ram fail stays clear
        if (rx_fifo_sel) begin
          next_st.put     = 3'(st.put + 3'h1);
          next_st.put_idx = 3'(st.put + 3'h1);
        end else begin
          next_st.ndat[st.fcfg[20:16]] = 1'b1;
        end
        next_st.irq_st[ctx_pkg::IRQ_RXNEW] = 1'b1;
        next_st.rx = ctx_pkg::CTX_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st      <= '0;
      st.ctrl <= ctx_pkg::CTRL_RESET;
      st.rx   <= ctx_pkg::CTX_IDLE;
    end else begin
      st <= next_st;
    end
  end
  // ram fail flag never raised by a store
  mraf_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    !st.irq_st[ctx_pkg::IRQ_MRAF]) else $error("ram fail flag set");
  // a cached word is written once
  word_once_a: assert property (@(posedge clk) disable iff (!nrst)
    st.rx == ctx_pkg::CTX_DATA && ram_we && !rx_word_valid |=> !(ram_we && st.rx == ctx_pkg::CTX_DATA))
    else $error("word duplicated");
  filt_start_a: assert property (@(posedge clk) disable iff (!nrst)
    st.rx == ctx_pkg::CTX_IDLE && rx_start |=> st.filter_index == 3'h0) else $error("filter not from zero");
endmodule : ctx_top

// >>> rtl/ctx_txbuf.sv
// one tx buffer slot: pending, cancel finished and occurred flags, latched frame data
// assumes protocol engine pulses per buffer; one buffer on the bus at a time
`timescale 1ns/10ps
module ctx_txbuf (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        req_set,
  input  wire logic        cancel_set,
  input  wire logic        dar,
  input  wire logic        sof,
  input  wire logic        in_id,
  input  wire logic        done_ok,
  input  wire logic        done_err,
  input  wire logic [31:0] wr_data,
  input  wire logic        wr_en,
  output logic             pending,
  output logic             cancel_fin,
  output logic             occurred,
  output logic             active,
  output logic      [31:0] frame_data
);
  typedef struct packed {
    logic        pend;
    logic        cfin;
    logic        occ;
    logic        act;
    logic        creq;
    logic [31:0] buf_data;
    logic [31:0] frame;
  } ctx_tb_s;
  ctx_tb_s st, next_st;
  // flag and data update
  always_comb begin
    next_st = st;
    if (wr_en) next_st.buf_data = wr_data;
    if (req_set) begin
      next_st.pend = 1'b1;
      next_st.cfin = 1'b0;
      next_st.occ  = 1'b0;
      next_st.creq = 1'b0;
    end
    if (cancel_set && st.pend) next_st.creq = 1'b1;
    // latch data at start of frame
    if (sof && st.pend) begin
      next_st.act   = 1'b1;
      next_st.frame = st.buf_data;
    end
    // cancel only when not sending; during id bits the frame goes on
    if (next_st.creq && !st.act && !sof) begin
      next_st.pend = 1'b0;
      next_st.cfin = 1'b1;
      next_st.creq = 1'b0;
    end
    if (done_ok && st.act) begin
      next_st.act  = 1'b0;
      next_st.pend = 1'b0;
      next_st.occ  = 1'b1;
      next_st.creq = 1'b0;
    end
    // retry stays pending unless retransmit disabled
    if (done_err && st.act) begin
      next_st.act = 1'b0;
      if (dar) next_st.pend = 1'b0;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) st <= '0;
    else st <= next_st;
  end
  assign pending    = st.pend;
  assign cancel_fin = st.cfin;
  assign occurred   = st.occ;
  assign active     = st.act;
  assign frame_data = st.frame;
  // no cancel report while frame on bus
  cancel_on_bus_a: assert property (@(posedge clk) disable iff (!nrst)
    st.act && !done_ok && !done_err |=> !(cancel_fin && !$past(cancel_fin))) else $error("cancel during frame");
  occ_on_ok_a: assert property (@(posedge clk) disable iff (!nrst)
    done_ok && st.act |=> occurred && !pending) else $error("occurred not set");
  frame_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    st.act && $past(st.act) |-> $stable(frame_data)) else $error("frame data changed");
  retry_pend_a: assert property (@(posedge clk) disable iff (!nrst)
    done_err && st.act && !dar && !cancel_set && !st.creq |=> pending) else $error("retry lost");
  id_cancel_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    in_id && !done_ok && !done_err |=> pending && !cancel_fin) else $error("cancel during id bits");
endmodule : ctx_txbuf

// >>> testbench/ctx_pe_model.sv
// partner: protocol engine model giving tx frame events and the rx word stream
// assumes the bench calls its tasks, one frame at a time, all on clk
`timescale 1ns/10ps
module ctx_pe_model (
  input  wire logic  clk,
  output logic [1:0]  tx_sel,
  output logic        tx_sof,
  output logic        tx_in_id,
  output logic        tx_done_ok,
  output logic        tx_done_err,
  output logic        rx_start,
  output logic [28:0] rx_id,
  output logic        rx_esi,
  output logic        rx_xtd,
  output logic        rx_rtr,
  output logic        rx_fdf,
  output logic        rx_brs,
  output logic [3:0]  rx_dlc,
  output logic [15:0] rx_timestamp,
  output logic        rx_word_valid,
  output logic [31:0] rx_word,
  output logic        rx_end
);
  // idle levels at time zero
  initial begin
    {tx_sel, tx_sof, tx_in_id, tx_done_ok, tx_done_err} = '0;
    {rx_start, rx_id, rx_esi, rx_xtd, rx_rtr, rx_fdf, rx_brs, rx_dlc} = '0;
    {rx_word_valid, rx_word, rx_end, rx_timestamp} = '0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // start of frame of buffer b
  task automatic tx_start(input logic [1:0] b);
    @(posedge clk);
    tx_sel <= b;
    tx_sof <= 1'b1;
    @(posedge clk);
    tx_sof <= 1'b0;
  endtask : tx_start
  // identifier phase marker
  task automatic tx_id();
    @(posedge clk);
    tx_in_id <= 1'b1;
    @(posedge clk);
    tx_in_id <= 1'b0;
  endtask : tx_id
  // frame ends ok or with error; a retry needs another tx_start
  task automatic tx_end(input logic ok);
    @(posedge clk);
    tx_done_ok  <= ok;
    tx_done_err <= !ok;
    @(posedge clk);
    tx_done_ok  <= 1'b0;
    tx_done_err <= 1'b0;
  endtask : tx_end
  // frame with caller-given flags, two data words, slow like the bus
  task automatic rx_frame(input logic [28:0] id, input logic [3:0] dlc, input logic [4:0] fl,
                          input logic [15:0] ts);
    @(posedge clk);
    rx_start     <= 1'b1;
    rx_id        <= id;
    rx_dlc       <= dlc;
    rx_timestamp <= ts;
    {rx_esi, rx_xtd, rx_rtr, rx_fdf, rx_brs} <= fl;
    @(posedge clk);
    rx_start     <= 1'b0;
    rx_id        <= ~id;
    rx_dlc       <= ~dlc;
    rx_timestamp <= ~ts;
    {rx_esi, rx_xtd, rx_rtr, rx_fdf, rx_brs} <= ~fl;
    for (int i = 0; i < 2; i++) begin
      repeat (20) @(posedge clk);
      rx_word_valid <= 1'b1;
      rx_word       <= (i == 0) ? 32'h0403_0201 : 32'h0807_0605;
      @(posedge clk);
      rx_word_valid <= 1'b0;
      rx_word       <= ~rx_word;
    end
    repeat (20) @(posedge clk);
    rx_end <= 1'b1;
    @(posedge clk);
    rx_end <= 1'b0;
  endtask : rx_frame
endmodule : ctx_pe_model

// >>> testbench/testbench.sv
// testbench: axi4-lite register tests of tx cancel and rx store
// assumes ctx_top and the engine model share one 100 MHz clock
`timescale 1ns/10ps
module testbench;
  logic        clk, nrst, awvalid, wvalid, bready, arvalid, rready, ram_we, awready, wready;
  logic        bvalid, arready, rvalid, irq, tx_sof, tx_in_id, tx_done_ok, tx_done_err, rx_start;
  logic        rx_esi, rx_xtd, rx_rtr, rx_fdf, rx_brs, rx_word_valid, rx_end;
  logic [7:0]  awaddr, araddr, ram_addr;
  logic [31:0] wdata, ram_wdata, rdata, tx_frame_data, rx_word, rd;
  logic [3:0]  wstrb, rx_dlc;
  logic [1:0]  bresp, rresp, rsp, tx_sel;
  logic [28:0] rx_id;
  logic [15:0] rx_timestamp;
  int          n_errors, check_count;

  ctx_top i_dut (
    .clk, .nrst, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tx_sel, .tx_sof, .tx_in_id, .tx_done_ok,
    .tx_done_err, .tx_frame_data, .rx_start, .rx_id, .rx_xtd, .rx_rtr, .rx_esi, .rx_fdf, .rx_brs,
    .rx_dlc, .rx_timestamp, .rx_word_valid, .rx_word, .rx_end, .ram_host_we(ram_we),
    .ram_host_addr(ram_addr), .ram_host_wdata(ram_wdata), .irq
  );
  ctx_pe_model i_pe (
    .clk, .tx_sel, .tx_sof, .tx_in_id, .tx_done_ok, .tx_done_err, .rx_start, .rx_id, .rx_esi,
    .rx_xtd, .rx_rtr, .rx_fdf, .rx_brs, .rx_dlc, .rx_timestamp, .rx_word_valid, .rx_word, .rx_end
  );
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize
  // compare one 32-bit result
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  // axi write; handshakes sampled at the rising edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    tb = 1'b0;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!tb) begin
      @(posedge clk);
      ta = awvalid && (awready === 1'b1);
      tw = wvalid && (wready === 1'b1);
      tb = bready && (bvalid === 1'b1);
      rsp = bresp;
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end
  endtask : axi_wr
  // axi read
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    logic ta, tr;
    tr = 1'b0;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!tr) begin
      @(posedge clk);
      ta = arvalid && (arready === 1'b1);
      tr = rready && (rvalid === 1'b1);
      d = rdata;
      rsp = rresp;
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end
  endtask : axi_rd
  // read until masked value matches, bounded
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    logic [31:0] v;
    for (int i = 0; i < 40; i++) begin
      axi_rd(a, v);
      if ((v & m) === e) break;
    end
    check(nm, e, v & m);
  endtask : poll
  // filter element load into message ram
  task automatic ram_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    ram_we    <= 1'b1;
    ram_addr  <= a;
    ram_wdata <= d;
    @(posedge clk);
    ram_we <= 1'b0;
  endtask : ram_wr
  // watchdog
  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    summarize();
  end
  ////////////////////////////////////////////////////////////////////////////////
  // main test sequence
  initial begin
    nrst = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, ram_we} = '0;
    {awaddr, araddr, ram_addr, wdata, ram_wdata} = '0;
    wstrb = 4'hf;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    axi_rd(ctx_pkg::OFS_CTRL, rd);
    check("ctrl reset", ctx_pkg::CTRL_RESET, rd);
    axi_rd(8'h80, rd);
    check("unmapped resp", 32'h2, {30'h0, rsp});
    axi_wr(ctx_pkg::OFS_CTRL, 32'h1);
    poll(ctx_pkg::OFS_CTRL, 32'h1, 32'h1, "ctrl dar");
    axi_wr(ctx_pkg::OFS_CTRL, 32'h0);
    axi_wr(ctx_pkg::OFS_IRQEN, 32'h1);
    // plain frame, buffer rewritten mid-frame
    axi_wr(8'h40, 32'h1111_2222);
    axi_wr(ctx_pkg::OFS_REQ, 32'h1);
    poll(ctx_pkg::OFS_PEND, 32'h1, 32'h1, "pend buf0");
    i_pe.tx_start(2'd0);
    repeat (2) @(posedge clk);
    check("frame data", 32'h1111_2222, tx_frame_data);
    axi_wr(8'h40, 32'h3333_4444);
    check("frame data held", 32'h1111_2222, tx_frame_data);
    i_pe.tx_end(1'b1);
    poll(ctx_pkg::OFS_OCC, 32'h1, 32'h1, "occ buf0");
    poll(ctx_pkg::OFS_PEND, 32'h1, 32'h0, "free buf0");
    check("irq txdone", 32'h1, {31'h0, irq});
    axi_wr(ctx_pkg::OFS_IRQCLR, 32'h1);
    repeat (2) @(posedge clk);
    check("irq cleared", 32'h0, {31'h0, irq});
    // failed frame retried, cancel during identifier
    axi_wr(ctx_pkg::OFS_REQ, 32'h2);
    i_pe.tx_start(2'd1);
    i_pe.tx_end(1'b0);
    poll(ctx_pkg::OFS_PEND, 32'h2, 32'h2, "pend retry");
    i_pe.tx_start(2'd1);
    fork
      i_pe.tx_id();
      axi_wr(ctx_pkg::OFS_CANCEL, 32'h2);
    join
    axi_rd(ctx_pkg::OFS_CFIN, rd);
    check("no early cancel", 32'h0, rd & 32'h2);
    axi_rd(ctx_pkg::OFS_PEND, rd);
    check("still pending", 32'h2, rd & 32'h2);
    i_pe.tx_end(1'b1);
    poll(ctx_pkg::OFS_OCC, 32'h2, 32'h2, "occ buf1");
    // idle cancel, interrupt masked then enabled
    axi_wr(ctx_pkg::OFS_IRQEN, 32'h0);
    axi_wr(ctx_pkg::OFS_REQ, 32'h4);
    axi_wr(ctx_pkg::OFS_CANCEL, 32'h4);
    poll(ctx_pkg::OFS_CFIN, 32'h4, 32'h4, "cfin buf2");
    poll(ctx_pkg::OFS_PEND, 32'h4, 32'h0, "pend buf2");
    axi_rd(ctx_pkg::OFS_IRQST, rd);
    check("cancel status", 32'h2, rd & 32'h2);
    check("irq masked", 32'h0, {31'h0, irq});
    axi_wr(ctx_pkg::OFS_IRQEN, 32'h2);
    repeat (2) @(posedge clk);
    check("irq cancel", 32'h1, {31'h0, irq});
    axi_wr(ctx_pkg::OFS_IRQCLR, 32'h2);
    repeat (2) @(posedge clk);
    check("irq off", 32'h0, {31'h0, irq});
    repeat (200) @(posedge clk); // frame time before reuse
    axi_wr(8'h48, 32'h5555_6666);
    // reception into fifo, then dedicated buffer, then a miss
    axi_wr(ctx_pkg::OFS_FCFG, 32'h9fff_ffff);
    ram_wr(8'h00, 32'h8000_0123);
    for (int k = 1; k < 8; k++) begin
      ram_wr(8'(k), 32'h8000_0456);
    end
    i_pe.rx_frame(29'h123, 4'd8, 5'b01000, 16'h1234);
    poll(ctx_pkg::OFS_RXSTAT, 32'h7, 32'h1, "put index");
    axi_rd(ctx_pkg::OFS_IRQST, rd);
    check("rx new no ramfail", 32'h4, rd & 32'hc);
    check("fifo r0", 32'h4000_0123, i_dut.u_ram.mem[8'h20]);
    check("fifo r1", 32'h0008_1234, i_dut.u_ram.mem[8'h21]);
    check("fifo r2", 32'h0403_0201, i_dut.u_ram.mem[8'h22]);
    check("fifo r3", 32'h0807_0605, i_dut.u_ram.mem[8'h23]);
    axi_wr(ctx_pkg::OFS_FCFG, 32'h1fe3_ffff);
    i_pe.rx_frame(29'h456, 4'd8, 5'b10111, 16'h5678);
    poll(ctx_pkg::OFS_NDAT, 32'h8, 32'h8, "new data");
    check("buf r0", 32'ha000_0456, i_dut.u_ram.mem[8'h56]);
    check("buf r1", 32'h0138_5678, i_dut.u_ram.mem[8'h57]);
    check("buf r3", 32'h0807_0605, i_dut.u_ram.mem[8'h59]);
    axi_wr(ctx_pkg::OFS_NDAT, 32'h8);
    i_pe.rx_frame(29'h789, 4'd8, 5'b01000, 16'h0000);
    repeat (60) @(posedge clk);
    axi_rd(ctx_pkg::OFS_NDAT, rd);
    check("miss not stored", 32'h0, rd & 32'h8);
    axi_rd(ctx_pkg::OFS_RXSTAT, rd);
    check("put index kept", 32'h1, rd & 32'h7);
    summarize();
  end
endmodule : testbench
